// [design/ebcid_pkg.sv]
/*
  constants, enumerations and opcode match table for the instruction decoder core.
  assumes one oscillator clock domain and 16-bit program words from the fetch path.
*/
package ebcid_pkg;

  localparam int WORD_W = 16;
  localparam int OSC_PER_ICYC = 4;
  localparam logic [1:0] Q_FIRST = 2'h0;
  localparam logic [1:0] Q_LAST = 2'(OSC_PER_ICYC - 1);
  localparam logic [1:0] Q_RST = 2'h0;

  // second word of a double-word instruction
  localparam logic [3:0] SECOND_TAG = 4'hf;

  // quick-access region split and banks
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // status flag positions and masks
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  localparam logic [4:0] FLAGS_ALL = 5'h1f;
  localparam logic [4:0] FLAGS_ZN = 5'h14;
  localparam logic [4:0] STATUS_RST = 5'h00;

  // single opcodes, mask and value
  localparam logic [15:0] M_GOTO = 16'hff00;
  localparam logic [15:0] V_GOTO = 16'hef00;
  localparam logic [15:0] M_CALL = 16'hfe00;
  localparam logic [15:0] V_CALL = 16'hec00;
  localparam logic [15:0] M_LFSR = 16'hffc0;
  localparam logic [15:0] V_LFSR = 16'hee00;
  localparam logic [15:0] M_RET = 16'hfffc;
  localparam logic [15:0] V_RET = 16'h0010;
  localparam logic [15:0] M_TBL = 16'hfff8;
  localparam logic [15:0] V_TBL = 16'h0008;
  localparam logic [15:0] V_CALLW = 16'h0014;

  localparam int N_SKIP = 8;
  localparam logic [15:0] SKIP_M [0:N_SKIP-1] = '{16'hfe00, 16'hfe00, 16'hfe00, 16'hfc00,
                                                 16'hfc00, 16'hfc00, 16'hfc00, 16'hfe00};
  localparam logic [15:0] SKIP_V [0:N_SKIP-1] = '{16'h6200, 16'h6400, 16'h6000, 16'h2c00,
                                                 16'h3c00, 16'h4c00, 16'h4800, 16'h6600};
  localparam int N_EXT = 8;
  localparam logic [15:0] EXT_M [0:N_EXT-1] = '{16'hff00, 16'hff00, 16'hffc0, 16'hffc0,
                                               16'hff00, 16'hff80, 16'hff80, 16'hffff};
  localparam logic [15:0] EXT_V [0:N_EXT-1] = '{16'he800, 16'he900, 16'he8c0, 16'he9c0,
                                               16'hea00, 16'heb00, 16'heb80, 16'h0014};

  typedef enum logic [1:0] {ST_DECODE, ST_OPERAND, ST_FLUSH} ebcid_state_t;
  typedef enum logic [2:0] {CL_NONE, CL_BYTE, CL_BIT, CL_LIT, CL_CTRL, CL_MOVE} ebcid_class_t;
  typedef enum logic [1:0] {TA_NONE, TA_POST_INC, TA_POST_DEC, TA_PRE_INC} ebcid_tbl_act_t;

endpackage

// [design/ebcid_core.sv]
/*
  instruction word decoder and instruction cycle sequencer of an 8-bit core.
  assumes fetch_word, cond_true, bsr and alu_flags come from logic on ref_clk;
  the fetch path presents the next word whenever fetch_take is high.
*/
// Implementation choices: the placing of the registers and the strobed register port.
// Function
// - single-word instructions split into opcode field and operand fields
// - exactly four double-word instructions carry 32 bits over two words
// - a lone word with top nibble all ones runs as a no-operation
// - plain single-word instruction finishes in one instruction cycle
// - true test or single-word program counter change adds one no-operation cycle
// - every double-word instruction takes two instruction cycles
// - an instruction cycle is four oscillator periods
// - destination bit 0 sends result to accumulator, 1 to file register
// - access bit 0 uses quick-access region, 1 uses bank select register
// - three-bit position field picks bit 0 to 7 of the register
// - file operand is 8-bit address or 2-bit pointer selector
// - register move decodes 12-bit source and 12-bit destination addresses
// - literal field is 8, 11, 12 or 20 bits, may load a pointer
// - five arithmetic flags are held and updated from results
// - control operands: program address, call/return mode, table mode or none
// - fast bit 1 uses shadow registers, 0 leaves them untouched
// - table transfers carry a pointer mode field; one encoding leaves it
// - other modes post-increment, post-decrement or pre-increment the pointer
// - recognise 75 standard plus 8 extended instructions
`timescale 1ns/1ps

module ebcid_core
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [15:0] fetch_word,
  input wire logic cond_true,
  input wire logic [3:0] bank_select_register,
  input wire logic [4:0] alu_flags,
  output logic fetch_take,
  output logic cyc_start,
  output logic exec_valid,
  output logic exec_nop,
  output ebcid_pkg::ebcid_class_t exec_class,
  output logic exec_two_word,
  output logic exec_operand,
  output logic dest_to_file,
  output logic bank_from_bsr,
  output logic [11:0] file_addr,
  output logic [1:0] fsr_sel,
  output logic [2:0] bit_pos,
  output logic [7:0] bit_mask,
  output logic [11:0] src_addr,
  output logic [11:0] dst_addr,
  output logic [19:0] literal_val,
  output logic pc_alter,
  output logic cond_test,
  output logic fast_sel,
  output logic shadow_save,
  output logic shadow_restore,
  output logic tbl_read,
  output logic tbl_write,
  output ebcid_pkg::ebcid_tbl_act_t tbl_ptr_act,
  output logic ext_instr,
  output logic [4:0] flag_update,
  output logic [4:0] status_flags
);

  typedef struct packed {
    logic valid;
    logic nop;
    ebcid_pkg::ebcid_class_t cls;
    logic two_word;
    logic dest_file;
    logic bank_bsr;
    logic [11:0] addr;
    logic [2:0] bit_pos;
    logic [7:0] bit_mask;
    logic [1:0] fsr_sel;
    logic [11:0] src;
    logic [11:0] dst;
    logic [19:0] lit;
    logic pc_alter;
    logic cond;
    logic fast;
    logic sh_save;
    logic sh_restore;
    logic tbl_rd;
    logic tbl_wr;
    ebcid_pkg::ebcid_tbl_act_t tbl_act;
    logic ext;
    logic [4:0] flag_mask;
    logic is_jump;
    logic is_lfsr;
  } ebcid_dec_t;

  typedef struct packed {
    logic [1:0] q;
    ebcid_pkg::ebcid_state_t st;
    logic [4:0] status;
    ebcid_dec_t dec;
  } ebcid_regs_t;
  localparam ebcid_regs_t REGS_RST = '{q: ebcid_pkg::Q_RST, st: ebcid_pkg::ST_DECODE,
                                       status: ebcid_pkg::STATUS_RST, dec: '0};
  logic [1:0] rst_sync_ff;
  logic rst_n;
  ebcid_regs_t r_ff;
  ebcid_regs_t nxt_r;
  function automatic logic op_match(input logic [15:0] w, input logic [15:0] m, input logic [15:0] v);
    op_match = (w & m) == v;
  endfunction
  // quick-access or banked 12-bit address
  function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f, input logic [3:0] bank);
    logic [3:0] b;
    b = bank;
    if (!a)
      b = (f < ebcid_pkg::ACCESS_SPLIT) ? ebcid_pkg::ACCESS_LO_BANK : ebcid_pkg::ACCESS_HI_BANK;
    eff_addr = {b, f};
  endfunction

  function automatic ebcid_dec_t decode_word(input logic [15:0] w, input logic [3:0] bank);
    ebcid_dec_t d;
    d = '0;
    d.valid = 1'b1;
    d.cls = ebcid_pkg::CL_CTRL;
    d.lit = {12'h000, w[7:0]};
    d.bank_bsr = w[8];
    d.addr = eff_addr(w[8], w[7:0], bank);
    case (w[15:12])
      4'h0:
      begin
        if (w[11:8] == 4'h0)
        begin
          d.cls = ebcid_pkg::CL_CTRL;
          if (op_match(w, ebcid_pkg::M_RET, ebcid_pkg::V_RET))
          begin
            d.pc_alter = 1'b1;
            d.fast = w[0];
            d.sh_restore = w[0];
          end
          if (w == ebcid_pkg::V_CALLW)
            d.pc_alter = 1'b1;
          if (op_match(w, ebcid_pkg::M_TBL, ebcid_pkg::V_TBL))
          begin
            d.tbl_rd = !w[2];
            d.tbl_wr = w[2];
            d.tbl_act = ebcid_pkg::ebcid_tbl_act_t'(w[1:0]);
          end
        end
        else if (w[11] || w[11:8] == 4'h1)
        begin
          d.cls = ebcid_pkg::CL_LIT;
          if (w[11:8] == 4'hf || w[11:8] == 4'h8)
            d.flag_mask = ebcid_pkg::FLAGS_ALL;
          else if (w[11:8] == 4'h9 || w[11:8] == 4'ha || w[11:8] == 4'hb)
            d.flag_mask = ebcid_pkg::FLAGS_ZN;
          d.pc_alter = (w[11:8] == 4'hc);
        end
        else
        begin
          d.cls = ebcid_pkg::CL_BYTE;
          d.dest_file = w[9];
          d.flag_mask = ebcid_pkg::FLAGS_ZN;
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
      begin
        d.cls = ebcid_pkg::CL_BYTE;
        d.dest_file = w[9];
        d.flag_mask = (w[15:12] == 4'h2 || w[15:12] == 4'h5) ? ebcid_pkg::FLAGS_ALL : ebcid_pkg::FLAGS_ZN;
      end
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb:
      begin
        d.cls = ebcid_pkg::CL_BIT;
        d.bit_pos = w[11:9];
        d.bit_mask = 8'h01 << w[11:9];
        d.cond = (w[15:12] == 4'ha || w[15:12] == 4'hb);
      end
      4'hc:
      begin
        d.cls = ebcid_pkg::CL_MOVE;
        d.two_word = 1'b1;
        d.src = w[11:0];
      end
      4'hd:
      begin
        d.pc_alter = 1'b1;
        d.lit = {9'h000, w[10:0]};
      end
      4'he:
      begin
        if (!w[11])
          d.cond = 1'b1;
        else if (!w[10])
        begin
          d.cls = ebcid_pkg::CL_LIT;
          d.fsr_sel = w[7:6];
        end
        else if (op_match(w, ebcid_pkg::M_CALL, ebcid_pkg::V_CALL)
                 || op_match(w, ebcid_pkg::M_GOTO, ebcid_pkg::V_GOTO))
        begin
          d.two_word = 1'b1;
          d.is_jump = 1'b1;
          d.fast = !w[9] && w[8];
        end
        else if (op_match(w, ebcid_pkg::M_LFSR, ebcid_pkg::V_LFSR))
        begin
          d.cls = ebcid_pkg::CL_LIT;
          d.two_word = 1'b1;
          d.is_lfsr = 1'b1;
          d.fsr_sel = w[5:4];
        end
      end
      default:
      begin
        d.cls = ebcid_pkg::CL_NONE;
        d.nop = 1'b1;
      end
    endcase
    for (int i = 0; i < ebcid_pkg::N_SKIP; i++)
      if (op_match(w, ebcid_pkg::SKIP_M[i], ebcid_pkg::SKIP_V[i]))
        d.cond = 1'b1;
    for (int i = 0; i < ebcid_pkg::N_EXT; i++)
      if (op_match(w, ebcid_pkg::EXT_M[i], ebcid_pkg::EXT_V[i]))
        d.ext = 1'b1;
    decode_word = d;
  endfunction

  // second word completes the operand of the held first word
  function automatic ebcid_dec_t join_second(input ebcid_dec_t f, input logic [15:0] w);
    ebcid_dec_t d;
    d = f;
    d.flag_mask = 5'h00;
    if (f.is_jump)
    begin
      d.lit = {w[11:0], f.lit[7:0]};
      d.pc_alter = 1'b1;
      d.sh_save = f.fast;
    end
    if (f.is_lfsr)
      d.lit = {8'h00, f.lit[3:0], w[7:0]};
    if (f.cls == ebcid_pkg::CL_MOVE)
      d.dst = w[11:0];
    join_second = d;
  endfunction

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.q = r_ff.q + 2'h1;
    if (r_ff.q == ebcid_pkg::Q_LAST)
    begin
      if (r_ff.dec.valid)
        nxt_r.status = (r_ff.status & ~r_ff.dec.flag_mask) | (alu_flags & r_ff.dec.flag_mask);
      if (r_ff.st == ebcid_pkg::ST_DECODE && r_ff.dec.two_word)
      begin
        nxt_r.st = ebcid_pkg::ST_OPERAND;
        nxt_r.dec = join_second(r_ff.dec, fetch_word);
      end
      else if (r_ff.st == ebcid_pkg::ST_DECODE && (r_ff.dec.pc_alter || (r_ff.dec.cond && cond_true)))
      begin
        nxt_r.st = ebcid_pkg::ST_FLUSH;
        nxt_r.dec = '0;
        nxt_r.dec.valid = 1'b1;
        nxt_r.dec.nop = 1'b1;
      end
      else
      begin
        nxt_r.st = ebcid_pkg::ST_DECODE;
        nxt_r.dec = decode_word(fetch_word, bank_select_register);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      r_ff <= REGS_RST;
    else
      r_ff <= nxt_r;
  end

  assign fetch_take = rst_n && (r_ff.q == ebcid_pkg::Q_LAST);
  assign cyc_start = rst_n && (r_ff.q == ebcid_pkg::Q_FIRST);
  assign exec_valid = r_ff.dec.valid;
  assign exec_nop = r_ff.dec.nop;
  assign exec_class = r_ff.dec.cls;
  assign exec_two_word = r_ff.dec.two_word;
  assign exec_operand = (r_ff.st == ebcid_pkg::ST_OPERAND);
  assign dest_to_file = r_ff.dec.dest_file;
  assign bank_from_bsr = r_ff.dec.bank_bsr;
  assign file_addr = r_ff.dec.addr;
  assign fsr_sel = r_ff.dec.fsr_sel;
  assign bit_pos = r_ff.dec.bit_pos;
  assign bit_mask = r_ff.dec.bit_mask;
  assign src_addr = r_ff.dec.src;
  assign dst_addr = r_ff.dec.dst;
  assign literal_val = r_ff.dec.lit;
  assign pc_alter = r_ff.dec.pc_alter;
  assign cond_test = r_ff.dec.cond;
  assign fast_sel = r_ff.dec.fast;
  assign shadow_save = r_ff.dec.sh_save;
  assign shadow_restore = r_ff.dec.sh_restore;
  assign tbl_read = r_ff.dec.tbl_rd;
  assign tbl_write = r_ff.dec.tbl_wr;
  assign tbl_ptr_act = r_ff.dec.tbl_act;
  assign ext_instr = r_ff.dec.ext;
  assign flag_update = r_ff.dec.flag_mask;
  assign status_flags = r_ff.status;

  // checks
  logic new_word;
  assign new_word = fetch_take && (nxt_r.st == ebcid_pkg::ST_DECODE);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_icycle_four: assert property (cyc_start |=> !cyc_start [*3] ##1 cyc_start)
    else $error("instruction cycle is not four clocks");
  chk_lone_second: assert property (new_word && fetch_word[15:12] == ebcid_pkg::SECOND_TAG
    |=> exec_nop && exec_class == ebcid_pkg::CL_NONE && !pc_alter)
    else $error("lone second word not a no-operation");
  chk_two_word_join: assert property (fetch_take && r_ff.st == ebcid_pkg::ST_DECODE
    && r_ff.dec.two_word |=> exec_operand ##4 r_ff.st == ebcid_pkg::ST_DECODE)
    else $error("double-word did not take exactly two cycles");
  chk_flush_taken: assert property (fetch_take && r_ff.st == ebcid_pkg::ST_DECODE && !r_ff.dec.two_word
    && (r_ff.dec.pc_alter || (r_ff.dec.cond && cond_true)) |=> exec_nop ##4 r_ff.st == ebcid_pkg::ST_DECODE)
    else $error("taken branch lacks one no-operation cycle");
  chk_single_cycle: assert property (fetch_take && r_ff.st == ebcid_pkg::ST_DECODE && !r_ff.dec.two_word
    && !r_ff.dec.pc_alter && !(r_ff.dec.cond && cond_true) |=> r_ff.st == ebcid_pkg::ST_DECODE)
    else $error("plain instruction took extra cycle");
  chk_dest_route: assert property (new_word && fetch_word[15:12] == 4'h2
    |=> dest_to_file == $past(fetch_word[9]) && exec_class == ebcid_pkg::CL_BYTE)
    else $error("destination bit misrouted");
  chk_bank_banked: assert property (new_word && fetch_word[15:12] == 4'h2 && fetch_word[8]
    |=> bank_from_bsr && file_addr == {$past(bank_select_register), $past(fetch_word[7:0])})
    else $error("banked address wrong");
  chk_bank_access: assert property (new_word && fetch_word[15:12] == 4'h2 && !fetch_word[8]
    |=> !bank_from_bsr && file_addr[7:0] == $past(fetch_word[7:0]) && (file_addr[11:8] == ebcid_pkg::ACCESS_LO_BANK
    || file_addr[11:8] == ebcid_pkg::ACCESS_HI_BANK))
    else $error("quick-access address used bank select");
  chk_bit_mask: assert property (new_word && fetch_word[15:12] >= 4'h7 && fetch_word[15:12] <= 4'hb
    |=> exec_class == ebcid_pkg::CL_BIT && bit_pos == $past(fetch_word[11:9])
    && $onehot(bit_mask) && bit_mask[bit_pos])
    else $error("bit mask does not match position");
  chk_status_hold: assert property (!fetch_take |=> $stable(status_flags))
    else $error("status flags changed mid cycle");
  chk_fast_shadow: assert property (!fast_sel |-> !shadow_save && !shadow_restore)
    else $error("shadow touched without fast bit");
  chk_tbl_mode: assert property (new_word && op_match(fetch_word, ebcid_pkg::M_TBL, ebcid_pkg::V_TBL)
    |=> (tbl_read || tbl_write) && tbl_ptr_act == ebcid_pkg::ebcid_tbl_act_t'($past(fetch_word[1:0])))
    else $error("table pointer mode wrong");
  chk_move_addr: assert property (fetch_take && r_ff.st == ebcid_pkg::ST_DECODE
    && r_ff.dec.cls == ebcid_pkg::CL_MOVE && r_ff.dec.two_word |=> dst_addr == $past(fetch_word[11:0])
    && src_addr == $past(src_addr))
    else $error("move addresses wrong");
  cov_two_word: cover property (exec_two_word && !exec_operand ##4 exec_operand);
  cov_flush: cover property (fetch_take && r_ff.st == ebcid_pkg::ST_DECODE && r_ff.dec.cond && cond_true);
  cov_lone_second: cover property (new_word && fetch_word[15:12] == ebcid_pkg::SECOND_TAG);

endmodule

// [test/ebcid_fetch_model.sv]
/*
  behavioural program memory fetch path and datapath source for the decoder core.
  assumes the bench loads mem before releasing reset; each entry holds
  {cond_true, alu_flags, bsr, word} for one instruction cycle.
*/
`timescale 1ns/1ps

module ebcid_fetch_model
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fetch_take,
  output logic [15:0] fetch_word,
  output logic cond_true,
  output logic [3:0] bank_select_register,
  output logic [4:0] alu_flags
);
  logic [25:0] mem [0:31];
  logic [4:0] idx_ff;

  // next word is presented right after the edge that consumed the last one
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      idx_ff <= 5'h00;
    else if (fetch_take)
      idx_ff <= idx_ff + 5'h01;
  end

  assign {cond_true, alu_flags, bank_select_register, fetch_word} = mem[idx_ff];
endmodule

// [test/ebcid_core_bench.sv]
/*
  self-checking bench for the instruction decoder core.
  assumes the fetch model feeds one word per instruction cycle, with no stall.
*/
`timescale 1ns/1ps

module ebcid_core_bench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] fetch_word;
  logic cond_true;
  logic [3:0] bank_select_register;
  logic [4:0] alu_flags;
  logic fetch_take, cyc_start, exec_valid, exec_nop, exec_two_word, exec_operand;
  logic dest_to_file, bank_from_bsr, pc_alter, cond_test, fast_sel;
  logic shadow_save, shadow_restore, tbl_read, tbl_write, ext_instr;
  ebcid_pkg::ebcid_class_t exec_class;
  ebcid_pkg::ebcid_tbl_act_t tbl_ptr_act;
  logic [11:0] file_addr, src_addr, dst_addr;
  logic [1:0] fsr_sel;
  logic [2:0] bit_pos;
  logic [7:0] bit_mask;
  logic [19:0] literal_val;
  logic [4:0] flag_update, status_flags;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int timed = 0;
  int i;
  logic [15:0] prog_w [0:31] = '{16'h2750, 16'h1620, 16'h0e7f, 16'h2470, 16'h8e33, 16'h6200, 16'h6200, 16'h0000,
    16'hef34, 16'hf567, 16'h0e55, 16'hf0aa, 16'hc123, 16'hf456, 16'hee25, 16'hf0ab,
    16'hed12, 16'hf345, 16'h0013, 16'h0000, 16'hd005, 16'h0000, 16'h0008, 16'h0009,
    16'h000a, 16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'he805, 16'h0000};

  always #50 ref_clk = ~ref_clk;

  ebcid_fetch_model i_fm (.ref_clk(ref_clk), .resetn(resetn), .fetch_take(fetch_take), .fetch_word(fetch_word),
    .cond_true(cond_true), .bank_select_register(bank_select_register), .alu_flags(alu_flags));

  ebcid_core i_dut (.ref_clk(ref_clk), .resetn(resetn), .fetch_word(fetch_word), .cond_true(cond_true), .bank_select_register(bank_select_register),
    .alu_flags(alu_flags), .fetch_take(fetch_take), .cyc_start(cyc_start), .exec_valid(exec_valid),
    .exec_nop(exec_nop), .exec_class(exec_class), .exec_two_word(exec_two_word), .exec_operand(exec_operand),
    .dest_to_file(dest_to_file), .bank_from_bsr(bank_from_bsr), .file_addr(file_addr), .fsr_sel(fsr_sel),
    .bit_pos(bit_pos), .bit_mask(bit_mask), .src_addr(src_addr), .dst_addr(dst_addr), .literal_val(literal_val),
    .pc_alter(pc_alter), .cond_test(cond_test), .fast_sel(fast_sel), .shadow_save(shadow_save),
    .shadow_restore(shadow_restore), .tbl_read(tbl_read), .tbl_write(tbl_write), .tbl_ptr_act(tbl_ptr_act),
    .ext_instr(ext_instr), .flag_update(flag_update), .status_flags(status_flags));

  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // wait for the next consumed word, then look at its settled decode
  task nxt;
    int k;
    k = 0;
    do
    begin
      @(negedge ref_clk);
      k++;
    end
    while (fetch_take !== 1'b1 && k < 12);
    if (timed != 0)
      check(k, 4);
    timed = 1;
    @(posedge ref_clk);
    #1;
    check(cyc_start, 1'b1);
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    for (i = 0; i < 32; i++)
      i_fm.mem[i] = {1'b0, 5'h00, 4'h3, prog_w[i]};
    i_fm.mem[1][24:20] = 5'h1b;
    i_fm.mem[2][24:20] = 5'h04;
    i_fm.mem[3][24:20] = 5'h1f;
    i_fm.mem[7][25] = 1'b1;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    nxt();
    check(exec_class, ebcid_pkg::CL_BYTE);
    check(dest_to_file, 1'b1);
    check(bank_from_bsr, 1'b1);
    check(file_addr, 12'h350);
    check(flag_update, 5'h1f);
    check(exec_valid, 1'b1);
    nxt();
    check(file_addr, 12'h020);
    check(bank_from_bsr, 1'b0);
    check(flag_update, 5'h14);
    check(status_flags, 5'h1b);
    nxt();
    check(exec_class, ebcid_pkg::CL_LIT);
    check(literal_val, 20'h0007f);
    check(status_flags, 5'h0f);
    nxt();
    check(dest_to_file, 1'b0);
    check(file_addr, 12'hf70);
    check(status_flags, 5'h0f);
    $display("byte and literal tests done");
    nxt();
    check(exec_class, ebcid_pkg::CL_BIT);
    check(bit_pos, 3'h7);
    check(bit_mask, 8'h80);
    nxt();
    check(cond_test, 1'b1);
    nxt();
    check(exec_nop, 1'b0);
    check(cond_test, 1'b1);
    nxt();
    check(exec_nop, 1'b1);
    check(exec_class, ebcid_pkg::CL_NONE);
    $display("skip tests done");
    nxt();
    check(exec_two_word, 1'b1);
    check(exec_operand, 1'b0);
    nxt();
    check(exec_operand, 1'b1);
    check(pc_alter, 1'b1);
    check(literal_val, 20'h56734);
    nxt();
    check(literal_val, 20'h00055);
    check(exec_nop, 1'b0);
    nxt();
    check(exec_nop, 1'b1);
    nxt();
    check(exec_class, ebcid_pkg::CL_MOVE);
    check(src_addr, 12'h123);
    nxt();
    check(dst_addr, 12'h456);
    check(exec_operand, 1'b1);
    nxt();
    check(fsr_sel, 2'h2);
    nxt();
    check(literal_val, 20'h005ab);
    nxt();
    check(fast_sel, 1'b1);
    nxt();
    check(shadow_save, 1'b1);
    check(literal_val, 20'h34512);
    $display("double word tests done");
    nxt();
    check(shadow_restore, 1'b1);
    check(pc_alter, 1'b1);
    nxt();
    check(exec_nop, 1'b1);
    nxt();
    check(pc_alter, 1'b1);
    check(literal_val, 20'h00005);
    nxt();
    check(exec_nop, 1'b1);
    $display("branch tests done");
    for (i = 0; i < 8; i++)
    begin
      nxt();
      check(tbl_read, i < 4);
      check(tbl_write, i >= 4);
      check(tbl_ptr_act, i % 4);
    end
    nxt();
    check(ext_instr, 1'b1);
    nxt();
    check(ext_instr, 1'b0);
    $display("table and extended tests done");
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(negedge ref_clk);
    check(exec_valid, 1'b0);
    check(fetch_take, 1'b0);
    check(status_flags, 5'h00);
    @(posedge ref_clk);
    resetn <= 1'b1;
    timed = 0;
    nxt();
    check(exec_class, ebcid_pkg::CL_BYTE);
    check(file_addr, 12'h350);
    $display("reset test done");
    report_and_stop();
  end
endmodule
